// File: rtl/bfs_pkg.sv
// Shared constants for the bulk fault status formatter
package bfs_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_ADDR = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  // Control register bit positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_RS_FITTED = 1;
  localparam int CTRL_QUERY = 2;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [23:0] ADDR_RST = 24'h303030;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Reply framing characters
  localparam logic [7:0] CH_START = 8'h3E;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [39:0] CMD_ECHO = 40'h424353465F;
  // Top two bits of every packed character: bit 7 low, bit 6 high
  localparam logic [1:0] CHAR_TOP = 2'h1;
  // Largest stored fault count
  localparam logic [3:0] COUNT_MAX = 4'hA;
  // Frame positions
  localparam int FRAME_LEN = 29;
  localparam logic [4:0] POS_ADDR = 5'h01;
  localparam logic [4:0] POS_SLASH = 5'h04;
  localparam logic [4:0] POS_CMD = 5'h05;
  localparam logic [4:0] POS_CHAR = 5'h0A;
  localparam logic [4:0] POS_COMMA = 5'h19;
  localparam logic [4:0] POS_RS = 5'h1A;
  localparam logic [4:0] POS_CR = 5'h1B;
  localparam logic [4:0] POS_LF = 5'h1C;
  localparam int NUM_CHARS = 15;
  // Sender states
  typedef enum logic {ST_IDLE, ST_SEND} bfs_state_t;
endpackage

// File: rtl/bfs_formatter.sv
// Bulk fault status reply formatter with AXI4-Lite control registers
// Notes on behaviour
// - Query answered with full packed fault status
// - Fault flag reads one when present
// - Bit 6 high, reserved bits zero
// - Count characters hold stored faults 0..10
// - Modulator char: module fault, actual output
// - Modulator char 2: six synthesizer/channel faults
// - Modulator char 3: four faults, two reserved
// - Demod char: module fault, carrier detect
// - Demod char 2: six lock/channel faults
// - Demod char 3: programming, configuration, reserved
// - Transmit interface char: count, reserved top
// - Transmit interface char 2: six faults
// - Receive interface char: insert fault, count
// - Receive interface char 2: six faults
// - Receive interface char 3: six faults
// - Common char: module faults and count
// - Common char 2: supply faults, reserved
// - Backward alarm char: TX 1,2, count
// - Backward alarm char 2: TX 3,4, RX 1-3
// - Bit 0 carries RX backward alarm 4
// - Final char: Reed-Solomon unavailable seconds count
// - Absent option field empty, comma kept
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module bfs_formatter (
  input wire logic clock,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded query from the link parser
  input wire logic queryReq,
  // Fault sources
  input wire logic [3:0] modCount,
  input wire logic modFault,
  input wire logic txOutOn,
  input wire logic [5:0] modFlags2,
  input wire logic [3:0] modFlags3,
  input wire logic [3:0] demCount,
  input wire logic demFault,
  input wire logic carrierDetect,
  input wire logic [5:0] demFlags2,
  input wire logic [1:0] demFlags3,
  input wire logic [3:0] txIfCount,
  input wire logic [5:0] txIfFlags2,
  input wire logic [3:0] rxIfCount,
  input wire logic insertFault,
  input wire logic [5:0] rxIfFlags2,
  input wire logic [5:0] rxIfFlags3,
  input wire logic [3:0] comCount,
  input wire logic mcFault,
  input wire logic ifModFault,
  input wire logic [4:0] comFlags2,
  input wire logic [3:0] bwCount,
  input wire logic [1:0] txBwAlarm12,
  input wire logic [5:0] bwFlags2,
  input wire logic [3:0] rsUasCount,
  // Reply character stream
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic enable_q; // Replies allowed
  logic rsFitted_q; // Reed-Solomon option present
  logic kick_q; // Software query pulse
  logic [23:0] unitAddr_q; // Three address characters
  logic [7:0] dropCount_q; // Queries refused while disabled or busy
  logic awHeld_q; // Write address captured
  logic [3:0] awAddr_q;
  logic wHeld_q; // Write data captured
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic doWrite; // Both halves of a write held
  logic queryAny; // Query from pin or register
  logic accept; // Query taken this cycle
  bfs_pkg::bfs_state_t state_q;
  logic [4:0] pos_q; // Frame position being offered
  logic [7:0] frame_q [0:bfs_pkg::FRAME_LEN-1]; // Reply snapshot
  logic [7:0] charWord [0:bfs_pkg::NUM_CHARS]; // Live packed characters
  logic [7:0] txData_q;
  logic txValid_q;

  // Clamp a stored fault count to its documented ceiling
  function automatic logic [3:0] sat(input logic [3:0] n);
    sat = (n > bfs_pkg::COUNT_MAX) ? bfs_pkg::COUNT_MAX : n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Character packing, bit 7 low and bit 6 high throughout
  always_comb
  begin
    charWord[0] = {bfs_pkg::CHAR_TOP, modFault, txOutOn, sat(modCount)};
    charWord[1] = {bfs_pkg::CHAR_TOP, modFlags2};
    charWord[2] = {bfs_pkg::CHAR_TOP, modFlags3, 2'h0};
    charWord[3] = {bfs_pkg::CHAR_TOP, demFault, carrierDetect, sat(demCount)};
    charWord[4] = {bfs_pkg::CHAR_TOP, demFlags2};
    charWord[5] = {bfs_pkg::CHAR_TOP, demFlags3, 4'h0};
    charWord[6] = {bfs_pkg::CHAR_TOP, 2'h0, sat(txIfCount)};
    charWord[7] = {bfs_pkg::CHAR_TOP, txIfFlags2};
    charWord[8] = {bfs_pkg::CHAR_TOP, insertFault, 1'h0, sat(rxIfCount)};
    charWord[9] = {bfs_pkg::CHAR_TOP, rxIfFlags2};
    charWord[10] = {bfs_pkg::CHAR_TOP, rxIfFlags3};
    charWord[11] = {bfs_pkg::CHAR_TOP, mcFault, ifModFault, sat(comCount)};
    charWord[12] = {bfs_pkg::CHAR_TOP, comFlags2, 1'h0};
    charWord[13] = {bfs_pkg::CHAR_TOP, txBwAlarm12, sat(bwCount)};
    charWord[14] = {bfs_pkg::CHAR_TOP, bwFlags2};
    charWord[15] = {bfs_pkg::CHAR_TOP, 2'h0, sat(rsUasCount)};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query acceptance
  assign queryAny = queryReq | kick_q;
  assign accept = queryAny & enable_q & (state_q == bfs_pkg::ST_IDLE);

  // Snapshot the whole reply so it stays coherent while sent
  always_ff @(posedge clock)
  begin
    if (accept)
    begin
      frame_q[0] <= bfs_pkg::CH_START;
      frame_q[1] <= unitAddr_q[23:16];
      frame_q[2] <= unitAddr_q[15:8];
      frame_q[3] <= unitAddr_q[7:0];
      frame_q[bfs_pkg::POS_SLASH] <= bfs_pkg::CH_SLASH;
      for (int k = 0; k < 5; k++)
      begin
        frame_q[bfs_pkg::POS_CMD + k] <= bfs_pkg::CMD_ECHO[39 - 8*k -: 8];
      end
      for (int k = 0; k < bfs_pkg::NUM_CHARS; k++)
      begin
        frame_q[bfs_pkg::POS_CHAR + k] <= charWord[k];
      end
      frame_q[bfs_pkg::POS_COMMA] <= bfs_pkg::CH_COMMA;
      frame_q[bfs_pkg::POS_RS] <= charWord[bfs_pkg::NUM_CHARS];
      frame_q[bfs_pkg::POS_CR] <= bfs_pkg::CH_CR;
      frame_q[bfs_pkg::POS_LF] <= bfs_pkg::CH_LF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply sender, one character per stream handshake
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= bfs_pkg::ST_IDLE;
      pos_q <= 5'h00;
      txValid_q <= 1'b0;
      txData_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        bfs_pkg::ST_IDLE:
        begin
          // Start with the delimiter straight from the constant
          if (accept)
          begin
            state_q <= bfs_pkg::ST_SEND;
            pos_q <= 5'h00;
            txValid_q <= 1'b1;
            txData_q <= bfs_pkg::CH_START;
          end
        end
        bfs_pkg::ST_SEND:
        begin
          if (txReady)
          begin
            if (pos_q == bfs_pkg::POS_LF)
            begin
              // Line feed taken, frame over
              state_q <= bfs_pkg::ST_IDLE;
              txValid_q <= 1'b0;
            end
            else if (pos_q == bfs_pkg::POS_COMMA && !rsFitted_q)
            begin
              // Option absent: empty field, go on to the terminator
              pos_q <= bfs_pkg::POS_CR;
              txData_q <= bfs_pkg::CH_CR;
            end
            else
            begin
              pos_q <= pos_q + 5'h01;
              txData_q <= frame_q[pos_q + 5'h01];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refused query counter, saturating
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      dropCount_q <= 8'h00;
    end
    else if (queryAny && !accept && dropCount_q != 8'hFF)
    begin
      dropCount_q <= dropCount_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channels, address and data taken in either order
  assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= bfs_pkg::RESP_OK;
      awAddr_q <= 4'h0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end
    else
    begin
      // Capture address
      if (s_axi_awvalid && awready_q)
      begin
        awHeld_q <= 1'b1;
        awready_q <= 1'b0;
        awAddr_q <= s_axi_awaddr;
      end
      // Capture data
      if (s_axi_wvalid && wready_q)
      begin
        wHeld_q <= 1'b1;
        wready_q <= 1'b0;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      // Respond once both are held
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awAddr_q == bfs_pkg::OFF_CTRL || awAddr_q == bfs_pkg::OFF_ADDR
                    || awAddr_q == bfs_pkg::OFF_STAT) ? bfs_pkg::RESP_OK
                                                      : bfs_pkg::RESP_DECERR;
      end
      // Response taken, open the channels again
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      enable_q <= bfs_pkg::CTRL_RST[bfs_pkg::CTRL_EN];
      rsFitted_q <= bfs_pkg::CTRL_RST[bfs_pkg::CTRL_RS_FITTED];
      kick_q <= 1'b0;
      unitAddr_q <= bfs_pkg::ADDR_RST;
    end
    else
    begin
      kick_q <= 1'b0;
      if (doWrite && awAddr_q == bfs_pkg::OFF_CTRL && wStrb_q[0])
      begin
        enable_q <= wData_q[bfs_pkg::CTRL_EN];
        rsFitted_q <= wData_q[bfs_pkg::CTRL_RS_FITTED];
        kick_q <= wData_q[bfs_pkg::CTRL_QUERY];
      end
      if (doWrite && awAddr_q == bfs_pkg::OFF_ADDR)
      begin
        for (int b = 0; b < 3; b++)
        begin
          if (wStrb_q[b])
          begin
            unitAddr_q[8*b +: 8] <= wData_q[8*b +: 8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= bfs_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= bfs_pkg::RESP_OK;
      unique case (s_axi_araddr)
        bfs_pkg::OFF_CTRL: rdata_q <= {30'h0, rsFitted_q, enable_q};
        bfs_pkg::OFF_ADDR: rdata_q <= {8'h0, unitAddr_q};
        bfs_pkg::OFF_STAT: rdata_q <= {19'h0, pos_q, dropCount_q[7:0]} | {31'h0,
                                       (state_q == bfs_pkg::ST_SEND)} << 16;
        default:
        begin
          // Unmapped word
          rdata_q <= 32'h0;
          rresp_q <= bfs_pkg::RESP_DECERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign txData = txData_q;
  assign txValid = txValid_q;
  assign busy = (state_q == bfs_pkg::ST_SEND);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic inChars; // Offering a packed character
  assign inChars = txValid_q && pos_q >= bfs_pkg::POS_CHAR && pos_q <= bfs_pkg::POS_RS
                   && pos_q != bfs_pkg::POS_COMMA;

  sequence s_accept;
    accept;
  endsequence

  sequence s_stall;
    txValid_q && !txReady;
  endsequence

  property p_bit6;
    @(posedge clock) disable iff (sys_rst) inChars |-> txData_q[7:6] == 2'h1;
  endproperty
  a_bit6: assert property (p_bit6) else $error("packed char top bits wrong");

  property p_count;
    @(posedge clock) disable iff (sys_rst)
      inChars && txData_q[5:4] == 2'h0 && pos_q == bfs_pkg::POS_RS
      |-> txData_q[3:0] <= bfs_pkg::COUNT_MAX;
  endproperty
  a_count: assert property (p_count) else $error("count above ten");

  property p_start;
    @(posedge clock) disable iff (sys_rst)
      s_accept |=> txValid_q && txData_q == 8'h3E && pos_q == 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("reply does not open");

  property p_hold;
    @(posedge clock) disable iff (sys_rst) s_stall |=> txValid_q && $stable(txData_q);
  endproperty
  a_hold: assert property (p_hold) else $error("character changed under stall");

  property p_skip;
    @(posedge clock) disable iff (sys_rst)
      txValid_q && txReady && pos_q == 5'h19 && !rsFitted_q |=> txData_q == 8'h0D;
  endproperty
  a_skip: assert property (p_skip) else $error("absent field not empty");

  property p_comma;
    @(posedge clock) disable iff (sys_rst) txValid_q && pos_q == 5'h19 |-> txData_q == 8'h2C;
  endproperty
  a_comma: assert property (p_comma) else $error("comma missing");

  property p_outState;
    @(posedge clock) disable iff (sys_rst)
      s_accept |=> frame_q[10][4] == $past(txOutOn) && frame_q[13][4] == $past(carrierDetect);
  endproperty
  a_outState: assert property (p_outState) else $error("state bit not captured");

  property p_end;
    @(posedge clock) disable iff (sys_rst)
      txValid_q && txReady && pos_q == 5'h1C |-> txData_q == 8'h0A ##1 !txValid_q;
  endproperty
  a_end: assert property (p_end) else $error("frame does not end on line feed");

  property p_flag;
    @(posedge clock) disable iff (sys_rst)
      s_accept |=> frame_q[11][5:0] == $past(modFlags2) && frame_q[24][5:0] == $past(bwFlags2);
  endproperty
  a_flag: assert property (p_flag) else $error("fault flags misplaced");

endmodule
`default_nettype wire

// File: test/bfs_host_model.sv
// Host model that takes reply characters off the formatter's stream
`timescale 1ns/1ns
`default_nettype none
module bfs_host_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic slow
);
  // Captured reply characters
  logic [7:0] rxChar [0:255];
  // Characters taken so far
  int rxCount_q;
  // Alternating stall phase
  logic stall_q;
  ////////////////////////////////////////////////////////////////////////////
  // Toggle phase; a slow host accepts every other cycle only
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stall_q <= 1'b0;
    else
      stall_q <= ~stall_q;
  end
  assign txReady = slow ? stall_q : 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Take one character per handshake edge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rxCount_q <= 0;
    else if (txValid && txReady)
    begin
      rxChar[rxCount_q[7:0]] <= txData;
      rxCount_q <= rxCount_q + 1;
    end
  end
endmodule
`default_nettype wire

// File: test/bulk_fault_status_formatter_test.sv
// Self-checking bench for the bulk fault status formatter
`timescale 1ns/1ns
`default_nettype none
module bulk_fault_status_formatter_test;
  // Unit address programmed into the address register
  localparam logic [23:0] UNIT = 24'h414243;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  // Bus master side
  logic [3:0] awAddr = 4'h0;
  logic [3:0] arAddr = 4'h0;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, txValid, txReady, busy;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [7:0] txData;
  // Query pulse and host pacing
  logic queryReq = 1'b0, slow = 1'b0;
  // All fault inputs packed, modCount on top
  logic [83:0] flt = 84'h0;
  // Expected reply
  logic [7:0] expQ [$];
  int failures = 0, samplesChecked = 0;

  always #5 clock = ~clock;

  bfs_formatter dut (
    .clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .queryReq(queryReq),
    .modCount(flt[83:80]), .modFault(flt[79]), .txOutOn(flt[78]), .modFlags2(flt[77:72]),
    .modFlags3(flt[71:68]), .demCount(flt[67:64]), .demFault(flt[63]),
    .carrierDetect(flt[62]), .demFlags2(flt[61:56]), .demFlags3(flt[55:54]),
    .txIfCount(flt[53:50]), .txIfFlags2(flt[49:44]), .rxIfCount(flt[43:40]),
    .insertFault(flt[39]), .rxIfFlags2(flt[38:33]), .rxIfFlags3(flt[32:27]),
    .comCount(flt[26:23]), .mcFault(flt[22]), .ifModFault(flt[21]), .comFlags2(flt[20:16]),
    .bwCount(flt[15:12]), .txBwAlarm12(flt[11:10]), .bwFlags2(flt[9:4]),
    .rsUasCount(flt[3:0]),
    .txData(txData), .txValid(txValid), .txReady(txReady), .busy(busy)
  );

  bfs_host_model host (
    .clock(clock), .sys_rst(sys_rst), .txData(txData), .txValid(txValid),
    .txReady(txReady), .slow(slow)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bus write, address and data offered together
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
      n++;
    end
    while (bValid !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      failures++;
      end_of_test();
    end
    chk(bResp, er);
  endtask

  // Bus read
  task automatic axr(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arReady)
        arValid <= 1'b0;
      n++;
    end
    while (rValid !== 1'b1 && n < 100);
    d = rData;
    if (n >= 100)
    begin
      failures++;
      end_of_test();
    end
    chk(rResp, er);
  endtask

  // Stored-fault count limited to ten
  function automatic logic [3:0] cl(input logic [3:0] c);
    return (c > 4'hA) ? 4'hA : c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Expected reply for one fault pattern
  task automatic build(input logic [83:0] f, input logic rs);
    expQ = {8'h3E, UNIT[23:16], UNIT[15:8], UNIT[7:0], 8'h2F};
    for (int i = 4; i >= 0; i--)
      expQ.push_back(bfs_pkg::CMD_ECHO[i*8 +: 8]);
    expQ.push_back({2'h1, f[79], f[78], cl(f[83:80])});
    expQ.push_back({2'h1, f[77:72]});
    expQ.push_back({2'h1, f[71:68], 2'h0});
    expQ.push_back({2'h1, f[63], f[62], cl(f[67:64])});
    expQ.push_back({2'h1, f[61:56]});
    expQ.push_back({2'h1, f[55:54], 4'h0});
    expQ.push_back({4'h4, cl(f[53:50])});
    expQ.push_back({2'h1, f[49:44]});
    expQ.push_back({2'h1, f[39], 1'b0, cl(f[43:40])});
    expQ.push_back({2'h1, f[38:33]});
    expQ.push_back({2'h1, f[32:27]});
    expQ.push_back({2'h1, f[22], f[21], cl(f[26:23])});
    expQ.push_back({2'h1, f[20:16], 1'b0});
    expQ.push_back({2'h1, f[11:10], cl(f[15:12])});
    expQ.push_back({2'h1, f[9:4]});
    expQ.push_back(8'h2C);
    if (rs)
      expQ.push_back({4'h4, cl(f[3:0])});
    expQ.push_back(8'h0D);
    expQ.push_back(8'h0A);
  endtask

  // Reset values, unmapped and read-only places
  task automatic t_regs;
    logic [31:0] d;
    axr(bfs_pkg::OFF_CTRL, d, bfs_pkg::RESP_OK);
    chk(d, 32'h1);
    axr(bfs_pkg::OFF_ADDR, d, bfs_pkg::RESP_OK);
    chk(d, 32'h303030);
    axr(4'hC, d, bfs_pkg::RESP_DECERR);
    chk(d, 32'h0);
    axw(4'hC, 32'hFFFFFFFF, bfs_pkg::RESP_DECERR);
    axw(bfs_pkg::OFF_STAT, 32'hFFFF, bfs_pkg::RESP_OK);
    axr(bfs_pkg::OFF_STAT, d, bfs_pkg::RESP_OK);
    chk(d, 32'h0);
    axw(bfs_pkg::OFF_ADDR, {8'h0, UNIT}, bfs_pkg::RESP_OK);
    axr(bfs_pkg::OFF_ADDR, d, bfs_pkg::RESP_OK);
    chk(d, {8'h0, UNIT});
  endtask

  // One reply; dbl adds a query while busy, inputs change after a pin query
  task automatic t_frame(input logic [83:0] pat, input logic rs, input logic viaReg,
                         input logic s, input logic dbl);
    int base;
    int n;
    flt <= pat;
    slow <= s;
    axw(bfs_pkg::OFF_CTRL, {29'h0, 1'b0, rs, 1'b1}, bfs_pkg::RESP_OK);
    build(pat, rs);
    base = host.rxCount_q;
    if (viaReg)
      axw(bfs_pkg::OFF_CTRL, {29'h0, 1'b1, rs, 1'b1}, bfs_pkg::RESP_OK);
    else
    begin
      queryReq <= 1'b1;
      @(posedge clock);
      queryReq <= 1'b0;
      flt <= ~pat;
    end
    if (dbl)
    begin
      repeat (4) @(posedge clock);
      queryReq <= 1'b1;
      @(posedge clock);
      queryReq <= 1'b0;
    end
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while ((busy !== 1'b0 || host.rxCount_q - base < expQ.size()) && n < 500);
    if (n >= 500)
    begin
      failures++;
      end_of_test();
    end
    chk(host.rxCount_q - base, expQ.size());
    foreach (expQ[i])
      chk(host.rxChar[base + i], expQ[i]);
  endtask

  // Queries while disabled or busy are dropped and counted
  task automatic t_refuse;
    logic [31:0] d;
    int base;
    axw(bfs_pkg::OFF_CTRL, 32'h0, bfs_pkg::RESP_OK);
    base = host.rxCount_q;
    queryReq <= 1'b1;
    @(posedge clock);
    queryReq <= 1'b0;
    repeat (20) @(posedge clock);
    chk(host.rxCount_q - base, 0);
    t_frame({21{4'h3}}, 1'b0, 1'b0, 1'b1, 1'b1);
    base = host.rxCount_q;
    repeat (20) @(posedge clock);
    chk(host.rxCount_q - base, 0);
    axr(bfs_pkg::OFF_STAT, d, bfs_pkg::RESP_OK);
    // Idle, position left on the line feed, two refused queries
    chk(d[16:0], {1'b0, 3'h0, bfs_pkg::POS_LF, 8'h02});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_frame(84'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    t_frame({21{4'hA}}, 1'b1, 1'b0, 1'b1, 1'b0);
    t_frame({21{4'h5}}, 1'b1, 1'b1, 1'b0, 1'b0);
    t_frame({84{1'b1}}, 1'b1, 1'b0, 1'b1, 1'b0);
    t_refuse();
    end_of_test();
  end
endmodule
`default_nettype wire
